// File: psb_pkg.sv
// Shared constants for the burst pseudo-static RAM controller and memory ends
`default_nettype none
package psb_pkg;
  localparam int DATA_W = 16;             // Data word width
  localparam int ADDR_W = 8;              // Modelled word address width
  localparam int CFG_W = 7;               // Width of config_word
  // config_word field positions
  localparam int CFG_BURST_WR_BIT = 0;    // 1: burst writes, 0: single writes
  localparam int CFG_WE_LEVEL_BIT = 1;    // 1: level control, 0: single pulse
  localparam int CFG_BURST_LSB = 2;       // burst_length_setting, 2 bits
  localparam int CFG_LAT_LSB = 4;         // read_latency_setting, 3 bits
  localparam logic [6:0] CFG_RESET = 7'h53; // Latency 5, 8-word wrap, level, burst writes
  // burst_length_setting codes
  localparam logic [1:0] BURST_8 = 2'h0;
  localparam logic [1:0] BURST_16 = 2'h1;
  localparam logic [1:0] BURST_CONT = 2'h2;
  localparam logic [7:0] MASK_8 = 8'h07;  // Wrap boundary masks
  localparam logic [7:0] MASK_16 = 8'h0f;
  localparam logic [7:0] MASK_CONT = 8'hff;
  localparam logic [7:0] LEN_8 = 8'h08;
  localparam logic [7:0] LEN_16 = 8'h10;
  // Recovery time after a terminated burst
  localparam int CLK_PERIOD_NS = 10;
  localparam int RECOV_NS = 30;
  localparam logic [7:0] RECOV_CYC = 8'((RECOV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Controller register byte offsets
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_CFG = 5'h04;
  localparam logic [4:0] REG_ADDR = 5'h08;
  localparam logic [4:0] REG_WDATA = 5'h0c;
  localparam logic [4:0] REG_COUNT = 5'h10;
  localparam logic [4:0] REG_RDATA = 5'h14;
  localparam logic [4:0] REG_STATUS = 5'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WRITE_BIT = 1;
endpackage : psb_pkg
`default_nettype wire

// File: psb_if.sv
// Pin-level link between the controller end and the memory end
`timescale 1ns/1ns
`default_nettype none
interface psb_if;
  logic chip_select_primary_n;  // Primary chip enable, low active
  logic adv_n;                  // Address valid, low active
  logic oe_n;                   // Output enable, low active
  logic we_n;                   // Write enable, low active
  logic [psb_pkg::ADDR_W-1:0] addr;
  logic [psb_pkg::DATA_W-1:0] dq_ctl;   // Controller drive of data pins
  logic dq_ctl_oe;
  logic [psb_pkg::DATA_W-1:0] dq_mem;   // Memory drive of data pins
  logic dq_mem_oe;
  logic [psb_pkg::DATA_W-1:0] dq_bus;   // Resolved data pin level
  logic wait_lvl;               // Wait indicator driven level
  logic wait_oe;                // Wait indicator enable
  logic [psb_pkg::CFG_W-1:0] config_word; // Configuration sequence payload
  logic cfg_load;               // One-cycle configuration strobe
  // Resolve the shared data pins; idle bus reads as zero
  assign dq_bus = dq_ctl_oe ? dq_ctl : (dq_mem_oe ? dq_mem : 16'h0000);
  modport ctl (output chip_select_primary_n, adv_n, oe_n, we_n, addr, dq_ctl, dq_ctl_oe,
               config_word, cfg_load, input dq_bus, wait_lvl, wait_oe);
  modport mem (input chip_select_primary_n, adv_n, oe_n, we_n, addr, dq_bus,
               config_word, cfg_load, output dq_mem, dq_mem_oe, wait_lvl, wait_oe);
endinterface : psb_if
`default_nettype wire

// File: psb_mem.sv
// Memory end: synchronous burst pseudo-static RAM array and burst sequencer
`timescale 1ns/1ns
`default_nettype none
module psb_mem
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  psb_if.mem link,
  output logic [psb_pkg::CFG_W-1:0] config_o
);
  typedef enum logic [1:0] {M_IDLE = 2'b00, M_LAT = 2'b01, M_DATA = 2'b10,
                            M_DONE = 2'b11} psb_mst_t;
  psb_mst_t state;
  logic [psb_pkg::CFG_W-1:0] cfg;       // Held mode
  logic [psb_pkg::DATA_W-1:0] mem [0:(1<<psb_pkg::ADDR_W)-1];
  logic [psb_pkg::ADDR_W-1:0] addr;     // Internal burst counter
  logic [7:0] count;                    // Words moved this burst
  logic [2:0] lat;                      // Edges left to first data
  logic is_wr;                          // Burst is a write
  logic [7:0] len;                      // Words in burst, 0 = 256 (count wraps to zero)
  logic [7:0] mask;                     // Wrap boundary
  logic suspend;                        // Suspend level seen this edge
  logic ev;                             // Data moves at this edge
  logic [2:0] rd_lat;                   // Programmed read latency
  logic [psb_pkg::ADDR_W-1:0] next_addr;

  assign config_o = cfg;
  assign rd_lat = cfg[psb_pkg::CFG_LAT_LSB +: 3];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration hold
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      cfg <= psb_pkg::CFG_RESET;
    else if (link.cfg_load)
      cfg <= link.config_word;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst length, wrap and suspend decode
  always_comb
  begin
    case (cfg[psb_pkg::CFG_BURST_LSB +: 2])
      psb_pkg::BURST_8:
      begin
        mask = psb_pkg::MASK_8;
        len = psb_pkg::LEN_8;
      end
      psb_pkg::BURST_16:
      begin
        mask = psb_pkg::MASK_16;
        len = psb_pkg::LEN_16;
      end
      default:
      begin
        mask = psb_pkg::MASK_CONT;
        len = 8'h00;
      end
    endcase
    if (is_wr && !cfg[psb_pkg::CFG_BURST_WR_BIT])
      len = 8'h01;
    // Write suspend only exists under level control
    suspend = is_wr ? (cfg[psb_pkg::CFG_WE_LEVEL_BIT] && link.we_n) : link.oe_n;
    next_addr = (addr & ~mask) | (8'(addr + 8'h01) & mask);
    // First word is never suspended; control levels act on this edge
    ev = !link.chip_select_primary_n &&
         ((state == M_LAT && lat == 3'h1) || (state == M_DATA && !suspend));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || link.chip_select_primary_n)
    begin
      state <= M_IDLE;
      count <= 8'h00;
    end
    else
    begin
      case (state)
        M_IDLE:
          if (!link.adv_n)
          begin
            addr <= link.addr;
            is_wr <= !link.we_n;
            lat <= link.we_n ? rd_lat : 3'(rd_lat - 3'h1);
            count <= 8'h00;
            state <= M_LAT;
          end
        M_LAT:
          if (lat != 3'h1)
            lat <= 3'(lat - 3'h1);
        default:
        begin
        end
      endcase
      // Counter frozen while suspended, resumes at the held address
      if (ev)
      begin
        addr <= next_addr;
        count <= 8'(count + 8'h01);
        state <= (8'(count + 8'h01) == len) ? M_DONE : M_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write on accepted words
  always_ff @(posedge core_clk_i)
  begin
    if (ev && is_wr)
      mem[addr] <= link.dq_bus;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data drive
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || link.chip_select_primary_n)
      link.dq_mem_oe <= 1'b0;
    else if (ev && !is_wr)
    begin
      link.dq_mem <= mem[addr];
      link.dq_mem_oe <= 1'b1;
    end
    else if (state == M_DATA && !is_wr && link.oe_n)
      link.dq_mem_oe <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wait indicator: low until one cycle before read data, held in suspend
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || link.chip_select_primary_n)
    begin
      link.wait_lvl <= 1'b0;
      link.wait_oe <= 1'b0;
    end
    else if (state == M_IDLE)
    begin
      link.wait_lvl <= !link.adv_n && !link.we_n;
      link.wait_oe <= !link.adv_n;
    end
    else if (state == M_LAT)
      link.wait_lvl <= is_wr || lat <= 3'h2;
    else if (state == M_DONE && suspend)
      link.wait_oe <= 1'b0;
  end
endmodule : psb_mem
`default_nettype wire

// File: psb_ctl.sv
// Controller end: Avalon-MM register slave driving bursts on the memory pins
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module psb_ctl
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic [4:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic busy_o,
  psb_if.ctl link
);
  typedef enum logic [2:0] {C_IDLE = 3'b000, C_ADDR = 3'b001, C_LAT = 3'b010,
                            C_XFER = 3'b011, C_SUSP = 3'b100,
                            C_RECOV = 3'b101} psb_cst_t;
  psb_cst_t state;
  logic [psb_pkg::CFG_W-1:0] cfg_reg;   // Mode to be loaded
  logic [7:0] addr_reg;                 // Burst start address
  logic [15:0] wdata_reg;               // Write pattern base
  logic [23:0] count_reg;               // Words, suspend point, suspend span
  logic dir_wr;                         // Burst direction
  logic [15:0] rdata_reg;               // Last word read
  logic [7:0] words;                    // Words moved this burst
  logic [2:0] lat;                      // Edges left to first word
  logic [7:0] scnt;                     // Suspend edges left
  logic [7:0] rec;                      // Recovery edges left
  logic ev_q;                           // Read word arrives this edge
  logic [31:0] be_mask;                 // Byte lane mask
  logic [31:0] wmerge;                  // Write data after lane merge
  logic acc;                            // Bus access accepted this edge
  logic ev;                             // Word moves at this edge
  logic [7:0] next_words;
  logic [7:0] blen;
  logic [7:0] limit;                    // Words to move, never zero
  logic [7:0] nw;
  logic we_level;
  logic susp_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Byte lane mask
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_be
      assign be_mask[gi*8 +: 8] = {8{byteenable_i[gi]}};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Event and length decode, mirrors the memory's own counting
  always_comb
  begin
    we_level = cfg_reg[psb_pkg::CFG_WE_LEVEL_BIT];
    acc = (read_i || write_i) && waitrequest_o;
    ev = (state == C_LAT && lat == 3'h1) ||
         (state == C_XFER && (dir_wr ? (!we_level || !link.we_n) : !link.oe_n));
    next_words = 8'(words + 8'h01);
    case (cfg_reg[psb_pkg::CFG_BURST_LSB +: 2])
      psb_pkg::BURST_8: blen = psb_pkg::LEN_8;
      psb_pkg::BURST_16: blen = psb_pkg::LEN_16;
      default: blen = 8'h00;
    endcase
    nw = (count_reg[7:0] == 8'h00) ? 8'h01 : count_reg[7:0];
    if (dir_wr && !cfg_reg[psb_pkg::CFG_BURST_WR_BIT])
      limit = 8'h01;
    else if (blen == 8'h00 || nw < blen)
      limit = nw;
    else
      limit = blen;
    // Suspend point of zero disables suspend; first word never suspended
    susp_ok = count_reg[15:8] != 8'h00 && count_reg[23:16] != 8'h00 &&
              (!dir_wr || we_level);
    wmerge = 32'(count_reg) & ~be_mask | writedata_i & be_mask;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave: one wait cycle, answer with waitrequest low
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      waitrequest_o <= 1'b1;
    else
      waitrequest_o <= !acc;
  end

  // Read data, set with the answer
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
      readdata_o <= 32'h0000_0000;
    else if (acc && read_i)
      case (address_i)
        psb_pkg::REG_CTRL: readdata_o <= {30'h0, dir_wr, 1'b0};
        psb_pkg::REG_CFG: readdata_o <= {25'h0, cfg_reg};
        psb_pkg::REG_ADDR: readdata_o <= {24'h0, addr_reg};
        psb_pkg::REG_WDATA: readdata_o <= {16'h0, wdata_reg};
        psb_pkg::REG_COUNT: readdata_o <= {8'h0, count_reg};
        psb_pkg::REG_RDATA: readdata_o <= {16'h0, rdata_reg};
        psb_pkg::REG_STATUS: readdata_o <= {16'h0, words, 7'h0, busy_o};
        default: readdata_o <= 32'h0000_0000; // Unmapped reads as zero
      endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers, written when waitrequest is seen low
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      cfg_reg <= psb_pkg::CFG_RESET;
      addr_reg <= 8'h00;
      wdata_reg <= 16'h0000;
      count_reg <= 24'h000001;
      dir_wr <= 1'b0;
      link.cfg_load <= 1'b0;
      link.config_word <= psb_pkg::CFG_RESET;
    end
    else
    begin
      link.cfg_load <= 1'b0;
      if (write_i && !waitrequest_o)
        case (address_i)
          psb_pkg::REG_CTRL:
            if (byteenable_i[0] && !busy_o)
              dir_wr <= writedata_i[psb_pkg::CTRL_WRITE_BIT];
          psb_pkg::REG_CFG:
            // Mode changes only between bursts
            if (byteenable_i[0] && !busy_o)
            begin
              cfg_reg <= writedata_i[psb_pkg::CFG_W-1:0];
              link.config_word <= writedata_i[psb_pkg::CFG_W-1:0];
              link.cfg_load <= 1'b1;
            end
          psb_pkg::REG_ADDR:
            if (byteenable_i[0])
              addr_reg <= writedata_i[7:0];
          psb_pkg::REG_WDATA:
            wdata_reg <= (wdata_reg & ~be_mask[15:0]) | (writedata_i[15:0] & be_mask[15:0]);
          psb_pkg::REG_COUNT:
            count_reg <= wmerge[23:0];
          default:
          begin
          end
        endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Burst sequencer driving the memory pins
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      state <= C_IDLE;
      busy_o <= 1'b0;
      link.chip_select_primary_n <= 1'b1;
      link.adv_n <= 1'b1;
      link.oe_n <= 1'b1;
      link.we_n <= 1'b1;
      link.addr <= 8'h00;
      link.dq_ctl <= 16'h0000;
      link.dq_ctl_oe <= 1'b0;
      words <= 8'h00;
      lat <= 3'h0;
      scnt <= 8'h00;
      rec <= 8'h00;
    end
    else
    begin
      case (state)
        C_IDLE:
          if (write_i && !waitrequest_o && address_i == psb_pkg::REG_CTRL &&
              byteenable_i[0] && writedata_i[psb_pkg::CTRL_START_BIT])
          begin
            busy_o <= 1'b1;
            link.chip_select_primary_n <= 1'b0;
            link.adv_n <= 1'b0;
            link.addr <= addr_reg;
            link.we_n <= !writedata_i[psb_pkg::CTRL_WRITE_BIT];
            link.dq_ctl <= wdata_reg;
            link.dq_ctl_oe <= writedata_i[psb_pkg::CTRL_WRITE_BIT];
            words <= 8'h00;
            state <= C_ADDR;
          end
        C_ADDR:
        begin
          link.adv_n <= 1'b1;
          if (dir_wr && !we_level)
            link.we_n <= 1'b1;
          link.oe_n <= dir_wr;
          lat <= dir_wr ? 3'(cfg_reg[psb_pkg::CFG_LAT_LSB +: 3] - 3'h1)
                        : cfg_reg[psb_pkg::CFG_LAT_LSB +: 3];
          state <= C_LAT;
        end
        C_LAT:
          if (lat != 3'h1)
            lat <= 3'(lat - 3'h1);
        C_SUSP:
          if (scnt == 8'h01)
          begin
            link.oe_n <= dir_wr;
            link.we_n <= !dir_wr;
            state <= C_XFER;
          end
          else
            scnt <= 8'(scnt - 8'h01);
        C_RECOV:
          if (rec == 8'h01)
          begin
            busy_o <= 1'b0;
            state <= C_IDLE;
          end
          else
            rec <= 8'(rec - 8'h01);
        default:
        begin
        end
      endcase
      if (ev)
      begin
        words <= next_words;
        link.dq_ctl <= 16'(wdata_reg + 16'(next_words));
        state <= C_XFER;
        if (next_words == limit)
        begin
          // Ends only after at least one word has moved
          link.chip_select_primary_n <= 1'b1;
          link.oe_n <= 1'b1;
          link.we_n <= 1'b1;
          link.dq_ctl_oe <= 1'b0;
          rec <= psb_pkg::RECOV_CYC;
          state <= C_RECOV;
        end
        else if (susp_ok && next_words == count_reg[15:8])
        begin
          link.oe_n <= 1'b1;
          link.we_n <= 1'b1;
          scnt <= count_reg[23:16];
          state <= C_SUSP;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read word capture, one edge after the memory drives it
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      ev_q <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      ev_q <= ev && !dir_wr;
      if (ev_q)
        rdata_reg <= link.dq_bus;
    end
  end
endmodule : psb_ctl
`default_nettype wire

// File: psb_link_assertions.sv
// Pin-level checks on the link between the controller end and the memory end
`timescale 1ns/1ns
`default_nettype none
module psb_link_assertions
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic chip_select_primary_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic dq_ctl_oe,
  input wire logic dq_mem_oe,
  input wire logic wait_lvl,
  input wire logic wait_oe,
  input wire logic cfg_load
);
  // Single clock domain, so clock and reset are named once
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////
  // Burst boundaries seen on the primary select
  sequence s_burst_end;
    $rose(chip_select_primary_n);
  endsequence
  sequence s_burst_start;
    $fell(chip_select_primary_n);
  endsequence
  // Three idle edges cover the recovery gap
  sequence s_recovery;
    chip_select_primary_n [*3];
  endsequence
  // Select held over the address edge and the shortest latency
  sequence s_first_word;
    !chip_select_primary_n [*3];
  endsequence
  ////////////////////////////////////////////////////////////////
  chk_recovery_gap: assert property (s_burst_end |-> s_recovery)
    else $error("select reasserted inside recovery gap");
  chk_no_early_end: assert property (s_burst_start |-> s_first_word)
    else $error("burst ended before its first word");
  // Suspension seen for a full edge must have released the data pins
  chk_suspend_float: assert property (!chip_select_primary_n && oe_n && $past(oe_n)
    |-> !dq_mem_oe)
    else $error("memory still drives data while read suspended");
  // Wait level frozen while output enable stays high inside a burst
  chk_wait_held: assert property (!chip_select_primary_n && wait_oe && $past(wait_oe)
    && oe_n && $past(oe_n) |-> $stable(wait_lvl))
    else $error("wait level moved during suspension");
  chk_term_release: assert property (chip_select_primary_n && $past(chip_select_primary_n)
    |-> !dq_mem_oe)
    else $error("memory drives data after termination");
  chk_cfg_idle: assert property (cfg_load |-> chip_select_primary_n && !dq_ctl_oe)
    else $error("configuration loaded inside a burst");
  chk_we_selected: assert property (!we_n |-> !chip_select_primary_n && oe_n)
    else $error("write enable low outside a selected write");
  chk_ctl_drive: assert property (dq_ctl_oe |-> !chip_select_primary_n && !dq_mem_oe)
    else $error("controller drives data outside a write burst");
  chk_oe_read: assert property (!oe_n |-> !chip_select_primary_n && we_n && !dq_ctl_oe)
    else $error("output enable low outside a read burst");
endmodule : psb_link_assertions
`default_nettype wire

// File: test_psram_burst_suspend_terminate.sv
// Self-checking bench joining the controller end to the memory end
`timescale 1ns/1ns
`default_nettype none
module test_psram_burst_suspend_terminate;
  logic core_clk_i; // Bench clock
  logic reset_i; // Synchronous reset
  logic [4:0] address_i; // Avalon byte address
  logic read_i;
  logic write_i;
  logic [31:0] writedata_i;
  logic [3:0] byteenable_i; // All lanes on throughout
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic busy_o;
  logic [6:0] config_o; // Mode held by the memory end
  logic [15:0] model [256]; // Reference copy of the array
  logic [31:0] q; // Last bus answer
  logic [31:0] r; // Random burst set-up, kept apart from bus answers
  logic [6:0] cfg;
  int bad_count; // Mismatches
  int comparisons; // Compares made
  ////////////////////////////////////////////////////////////////
  psb_if link_if ();
  psb_ctl psb_ctl_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .address_i(address_i),
    .read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
    .byteenable_i(byteenable_i), .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .busy_o(busy_o), .link(link_if.ctl));
  psb_mem psb_mem_inst (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link_if.mem),
    .config_o(config_o));
  psb_link_assertions psb_link_assertions_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
    .chip_select_primary_n(link_if.chip_select_primary_n), .oe_n(link_if.oe_n),
    .we_n(link_if.we_n), .dq_ctl_oe(link_if.dq_ctl_oe), .dq_mem_oe(link_if.dq_mem_oe),
    .wait_lvl(link_if.wait_lvl), .wait_oe(link_if.wait_oe), .cfg_load(link_if.cfg_load));
  ////////////////////////////////////////////////////////////////
  // Case-equal compare, counted
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Word slot inside the wrap boundary
  function automatic int idx(input int ad, input int k, input int len);
    return (ad & ~(len - 1)) | ((ad + k) & (len - 1));
  endfunction : idx
  // One Avalon transfer; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    address_i <= adr;
    writedata_i <= d;
    write_i <= wr;
    read_i <= ~wr;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while (waitrequest_o !== 1'b0 && n < 64);
    q = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
    if (n >= 64)
      bad_count++;
    // Let an edge pass so the strobe is never raised twice in one step
    @(posedge core_clk_i);
  endtask : bus
  // Program a burst, start it, wait for idle, then update or check the model
  task automatic run(input logic [6:0] c, input logic [7:0] ad, input logic [23:0] ct,
                     input logic wr, input logic [15:0] base);
    int len;
    int n;
    int k;
    len = (c[3:2] == 2'h0) ? 8 : ((c[3:2] == 2'h1) ? 16 : 256);
    n = (ct[7:0] == 8'h00) ? 1 : int'(ct[7:0]);
    if (n > len)
      n = len;
    // Single-write mode moves one word whatever the burst length
    if (wr && !c[0])
      n = 1;
    bus(1'b1, psb_pkg::REG_CFG, {25'h0, c});
    bus(1'b1, psb_pkg::REG_ADDR, {24'h0, ad});
    bus(1'b1, psb_pkg::REG_WDATA, {16'h0, base});
    bus(1'b1, psb_pkg::REG_COUNT, {8'h0, ct});
    bus(1'b1, psb_pkg::REG_CTRL, {30'h0, wr, 1'b1});
    k = 0;
    do
    begin
      bus(1'b0, psb_pkg::REG_STATUS, 32'h0);
      k++;
    end
    while (q[0] !== 1'b0 && k < 400);
    // A burst that never finishes counts as a mismatch
    if (k >= 400)
      bad_count++;
    check({24'h0, q[15:8]}, 32'(n));
    check({25'h0, config_o}, {25'h0, c});
    if (wr)
      for (k = 0; k < n; k++)
        model[idx(ad, k, len)] = base + 16'(k);
    else
    begin
      bus(1'b0, psb_pkg::REG_RDATA, 32'h0);
      check(q, {16'h0, model[idx(ad, n - 1, len)]});
    end
  endtask : run
  // Counts, verdict and end of run
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////////
  // Free-running 100 MHz clock
  initial
  begin
    core_clk_i = 1'b0;
    forever
      #5 core_clk_i = ~core_clk_i;
  end
  // Hang guard, well beyond the expected run length
  initial
  begin
    repeat (60000) @(posedge core_clk_i);
    bad_count++;
    end_of_test();
  end
  // Main sequence
  initial
  begin
    reset_i = 1'b1;
    address_i = 5'h00;
    read_i = 1'b0;
    write_i = 1'b0;
    writedata_i = 32'h0;
    byteenable_i = 4'hf;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(98));
    repeat (10) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    check({25'h0, config_o}, {25'h0, psb_pkg::CFG_RESET});
    // Fill with one endless burst, then five wrapped words from the top
    run(7'h5b, 8'h00, 24'h0000ff, 1'b1, 16'h1000);
    run(psb_pkg::CFG_RESET, 8'hff, 24'h000005, 1'b1, 16'h2000);
    run(psb_pkg::CFG_RESET, 8'hfc, 24'h000008, 1'b0, 16'h0);
    run(psb_pkg::CFG_RESET, 8'hfc, 24'h000004, 1'b0, 16'h0);
    // Twelve mode mixes over all four burst codes, with suspensions, written then read back
    for (int i = 0; i < 12; i++)
    begin
      cfg = {3'(3 + i % 4), 2'(i % 3 + i / 9), 1'(i / 2 % 2), 1'(i % 2)};
      r = {8'($urandom), 8'(1 + $urandom % 3), 8'($urandom % 4), 8'(1 + $urandom % 20)};
      run(cfg, r[31:24], r[23:0], 1'b1, 16'($urandom));
      run(cfg, r[31:24], r[23:0], 1'b0, 16'h0);
    end
    // Unmapped offset reads as zero
    bus(1'b0, 5'h1c, 32'h0);
    check(q, 32'h0);
    // Reset in mid-burst restores the mode and keeps the array
    bus(1'b1, psb_pkg::REG_COUNT, 32'h000000ff);
    bus(1'b1, psb_pkg::REG_CTRL, 32'h00000001);
    repeat (4) @(posedge core_clk_i);
    reset_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    check({25'h0, config_o}, {25'h0, psb_pkg::CFG_RESET});
    run(psb_pkg::CFG_RESET, 8'h13, 24'h000003, 1'b0, 16'h0);
    end_of_test();
  end
endmodule : test_psram_burst_suspend_terminate
`default_nettype wire
